// ==== hw/acr_click_gen.sv ====
// Keyclick burst generator
`timescale 1ns/10ps
module acr_click_gen
  import acr_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       clk_en_i,
  input  wire logic       start_i,
  input  wire logic [2:0] tone_i,
  input  wire logic [3:0] dur_i,
  output logic            tone_o,
  output logic            busy_o,
  output logic            done_o
);

  logic [CLICK_CNT_W-1:0] half_reg;
  logic [CLICK_CNT_W-1:0] half_next;
  logic [5:0]             edges_reg;
  logic [5:0]             edges_next;
  logic                   tone_reg;
  logic                   tone_next;
  logic                   busy_reg;
  logic                   busy_next;
  logic                   done_next;
  logic [CLICK_CNT_W-1:0] half_len;

  // Tone doubles per code from the lowest setting
  assign half_len = CLICK_CNT_W'(CLICK_BASE_HALF >> tone_i); // R19

  always_comb begin
    half_next  = half_reg;
    edges_next = edges_reg;
    tone_next  = tone_reg;
    busy_next  = busy_reg;
    done_next  = 1'b0;
    if (!busy_reg) begin
      // No restart while the trigger is still clearing
      if (start_i && !done_o) begin
        busy_next  = 1'b1;
        half_next  = half_len;
        // Periods = 2*(code+1), so edges = 4*(code+1)
        edges_next = {dur_i, 2'b00} + 6'd4; // R20
        tone_next  = 1'b1;
      end
    end else if (half_reg == CLICK_CNT_W'(1)) begin
      half_next  = half_len;
      edges_next = edges_reg - 6'd1;
      tone_next  = ~tone_reg;
      if (edges_reg == 6'd1) begin
        busy_next = 1'b0;
        tone_next = 1'b0;
        done_next = 1'b1; // R17
      end
    end else begin
      half_next = half_reg - CLICK_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      half_reg  <= '0;
      edges_reg <= '0;
      tone_reg  <= 1'b0;
      busy_reg  <= 1'b0;
      done_o    <= 1'b0;
    end else if (clk_en_i) begin
      half_reg  <= half_next;
      edges_reg <= edges_next;
      tone_reg  <= tone_next;
      busy_reg  <= busy_next;
      done_o    <= done_next;
    end
  end

  assign tone_o = tone_reg;
  assign busy_o = busy_reg;

endmodule : acr_click_gen

// ==== hw/acr_gain_stepper.sv ====
// Soft-stepping gain follower with completion flag
`timescale 1ns/10ps
module acr_gain_stepper
  import acr_pkg::*;
#(
  parameter int unsigned GAIN_W = 7
) (
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              step_i,
  input  wire logic              slow_i,
  input  wire logic [GAIN_W-1:0] target_i,
  input  wire logic [GAIN_W-1:0] reset_gain_i,
  output logic      [GAIN_W-1:0] applied_o,
  output logic                   done_o
);

  logic [GAIN_W-1:0] applied_reg;
  logic [GAIN_W-1:0] applied_next;
  logic              skip_reg;
  logic              skip_next;

  // One half-dB step per word strobe, or every second when slow
  always_comb begin
    applied_next = applied_reg;
    skip_next    = skip_reg;
    if (step_i) begin
      skip_next = slow_i ? ~skip_reg : 1'b0;
      if (!(slow_i && skip_reg)) begin
        if (applied_reg < target_i) begin
          applied_next = applied_reg + GAIN_W'(1);
        end else if (applied_reg > target_i) begin
          applied_next = applied_reg - GAIN_W'(1);
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      applied_reg <= reset_gain_i;
      skip_reg    <= 1'b0;
    end else if (clk_en_i) begin
      applied_reg <= applied_next;
      skip_reg    <= skip_next;
    end
  end

  assign applied_o = applied_reg;
  assign done_o    = (applied_reg == target_i);

endmodule : acr_gain_stepper

// ==== hw/acr_pkg.sv ====
// Package: register map, field layout, reset values and timing for the audio codec control block
package acr_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [2:0] FMT_RATE_OFS  = 3'h0;
  localparam logic [2:0] HS_GAIN_OFS   = 3'h1;
  localparam logic [2:0] DAC_GAIN_OFS  = 3'h2;
  localparam logic [2:0] SIDETONE_OFS  = 3'h3;
  localparam logic [2:0] CLICK_OFS     = 3'h4;

  // Reset values
  localparam logic [15:0] FMT_RATE_RST = 16'h0000;
  localparam logic [15:0] HS_GAIN_RST  = 16'hFF00;
  localparam logic [15:0] DAC_GAIN_RST = 16'hFFFF;
  localparam logic [15:0] SIDETONE_RST = 16'hC500;
  localparam logic [15:0] CLICK_RST    = 16'h4410;

  // Writable bit masks
  localparam logic [15:0] FMT_RATE_WMASK = 16'hCF3F;
  localparam logic [15:0] HS_GAIN_WMASK  = 16'hFFFF;
  localparam logic [15:0] DAC_GAIN_WMASK = 16'hFFFF;
  localparam logic [15:0] SIDETONE_WMASK = 16'hFFF8;
  localparam logic [15:0] CLICK_WMASK    = 16'hFFF0;

  // Field positions
  localparam int unsigned HS_MUTE_POS    = 15;
  localparam int unsigned HS_GAIN_LSB    = 8;
  localparam int unsigned AGC_EN_POS     = 0;
  localparam int unsigned LEFT_MUTE_POS  = 15;
  localparam int unsigned LEFT_VOL_LSB   = 8;
  localparam int unsigned RIGHT_MUTE_POS = 7;
  localparam int unsigned RIGHT_VOL_LSB  = 0;
  localparam int unsigned ST_MUTE_POS    = 15;
  localparam int unsigned ST_GAIN_LSB    = 8;
  localparam int unsigned ST_DONE_POS    = 0;
  localparam int unsigned CLICK_TRIG_POS = 15;
  localparam int unsigned CLICK_AMP_LSB  = 12;
  localparam int unsigned STEP_RATE_POS  = 11;
  localparam int unsigned CLICK_TONE_LSB = 8;
  localparam int unsigned CLICK_DUR_LSB  = 4;
  localparam int unsigned LEFT_DONE_POS  = 3;
  localparam int unsigned RIGHT_DONE_POS = 2;

  // Sidetone gain saturates at the 12 dB code
  localparam logic [6:0] ST_GAIN_MAX = 7'h5D;

  // Keyclick: 62.5 Hz lowest tone, half period at the 25 MHz core clock
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLICK_BASE_MHZ  = 62_500;
  localparam int unsigned CLICK_BASE_HALF = (CLK_HZ / 2) / CLICK_BASE_MHZ * 1000;
  localparam int unsigned CLICK_CNT_W     = 18;

  typedef enum logic [1:0] {
    ACR_FRAME_I2S,
    ACR_FRAME_DSP,
    ACR_FRAME_RIGHT,
    ACR_FRAME_LEFT
  } acr_framing_t;

endpackage : acr_pkg

// ==== hw/acr_regs.sv ====
// Audio codec control register bank with soft-stepping and keyclick
//
// How it works
// R1 - Highpass code zero off, else corner select
// R2 - Width code selects 16/20/24/32 bits
// R3 - Framing code: I2S, DSP, right, left
// R4 - Host uses right-justified only for integer ratios
// R5 - Playback divider code from eight ratios
// R6 - Record divider uses same eight ratios
// R7 - Headset mute and gain reset all ones
// R8 - Under autogain, reads return applied gain
// R9 - Autogain target level three-bit code
// R10 - Autogain time constant four-bit code
// R11 - Enable picks programmed or autogain gain; code takes autogain only while headset_selected_i is also set
// R12 - Per-channel playback mute, set at reset
// R13 - Per-channel seven-bit volume, all ones reset
// R14 - Sidetone mute and gain, saturating at 12dB
// R15 - Cellphone-to-record route bit, reset zero
// R16 - Sidetone done flag when applied equals set
// R17 - Click trigger self-clears after burst
// R18 - Click amplitude code, reset medium
// R19 - Click tone doubles per code
// R20 - Click length two times code plus one
// R21 - Step rate bit; noise flag under autogain
// R22 - Left and right done flags per channel
// R23 - Reference rate select 48.0 or 44.1
// R24 - Writing a gain clears its done flag
`timescale 1ns/10ps
module acr_regs
  import acr_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              clk_en_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  input  wire logic              record_word_strobe_i,
  input  wire logic              reference_rate_select_i,
  input  wire logic              headset_selected_i,
  input  wire logic [6:0]        autogain_gain_i,
  input  wire logic              autogain_mute_i,
  input  wire logic              autogain_noise_i,
  output logic [1:0]             rec_highpass_select_o,
  output logic [1:0]             sample_width_select_o,
  output acr_framing_t           serial_framing_select_o,
  output logic [2:0]             playback_rate_divider_o,
  output logic [2:0]             record_rate_divider_o,
  output logic                   reference_rate_select_o,
  output logic                   headset_input_mute_o,
  output logic [6:0]             headset_input_gain_o,
  output logic [2:0]             autogain_target_level_o,
  output logic [3:0]             autogain_time_constant_o,
  output logic                   autogain_enable_o,
  output logic                   left_playback_mute_o,
  output logic [6:0]             left_playback_volume_o,
  output logic                   right_playback_mute_o,
  output logic [6:0]             right_playback_volume_o,
  output logic                   sidetone_mute_o,
  output logic [6:0]             sidetone_gain_o,
  output logic                   cellphone_to_record_route_o,
  output logic [2:0]             click_amplitude_o,
  output logic                   click_tone_o,
  output logic                   click_active_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] strobe_sync_reg;
  logic [1:0] strobe_sync_next;
  logic       strobe_prev_reg;
  logic       strobe_prev_next;
  logic [1:0] refsel_sync_reg;
  logic [1:0] refsel_sync_next;
  logic       word_tick;

  always_comb begin
    strobe_sync_next = {strobe_sync_reg[0], record_word_strobe_i};
    strobe_prev_next = strobe_sync_reg[1];
    refsel_sync_next = {refsel_sync_reg[0], reference_rate_select_i};
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      strobe_sync_reg <= 2'b00;
      strobe_prev_reg <= 1'b0;
      refsel_sync_reg <= 2'b00;
    end else if (clk_en_i) begin
      strobe_sync_reg <= strobe_sync_next;
      strobe_prev_reg <= strobe_prev_next;
      refsel_sync_reg <= refsel_sync_next;
    end
  end

  // Rising edge of the word strobe paces soft-stepping
  assign word_tick = strobe_sync_reg[1] & ~strobe_prev_reg;
  assign reference_rate_select_o = refsel_sync_reg[1]; // R23

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [15:0] fmt_reg;
  logic [15:0] fmt_next;
  logic [15:0] hs_reg;
  logic [15:0] hs_next;
  logic [15:0] dac_reg;
  logic [15:0] dac_next;
  logic [15:0] st_reg;
  logic [15:0] st_next;
  logic [15:0] ck_reg;
  logic [15:0] ck_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        click_done;
  logic        click_busy;

  logic        agc_on;
  assign agc_on = hs_reg[AGC_EN_POS] & headset_selected_i;

  always_comb begin
    fmt_next = fmt_reg;
    hs_next  = hs_reg;
    dac_next = dac_reg;
    st_next  = st_reg;
    ck_next  = ck_reg;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        FMT_RATE_OFS: fmt_next = reg_wdata_i & FMT_RATE_WMASK; // R1
        HS_GAIN_OFS:  hs_next  = reg_wdata_i & HS_GAIN_WMASK; // R7
        DAC_GAIN_OFS: dac_next = reg_wdata_i & DAC_GAIN_WMASK; // R12
        SIDETONE_OFS: st_next  = reg_wdata_i & SIDETONE_WMASK; // R15
        CLICK_OFS: begin
          ck_next = reg_wdata_i & CLICK_WMASK; // R18
          // Step-rate bit turns read-only under autogain
          if (agc_on) begin
            ck_next[STEP_RATE_POS] = ck_reg[STEP_RATE_POS]; // R21
          end
        end
        default: ;
      endcase
    end
    // Self-clear wins only after burst ends; a fresh write retriggers
    if (click_done && !(reg_wr_i && reg_addr_i == CLICK_OFS)) begin
      ck_next[CLICK_TRIG_POS] = 1'b0; // R17
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fmt_reg <= FMT_RATE_RST;
      hs_reg  <= HS_GAIN_RST;
      dac_reg <= DAC_GAIN_RST;
      st_reg  <= SIDETONE_RST;
      ck_reg  <= CLICK_RST;
    end else if (clk_en_i) begin
      fmt_reg <= fmt_next;
      hs_reg  <= hs_next;
      dac_reg <= dac_next;
      st_reg  <= st_next;
      ck_reg  <= ck_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Soft-stepping gain followers

  logic [6:0] st_target;
  logic [6:0] left_applied;
  logic [6:0] right_applied;
  logic [6:0] st_applied;
  logic       left_done;
  logic       right_done;
  logic       st_done;
  logic       step_slow;

  // Codes above the 12 dB code hold 12 dB
  assign st_target = (st_reg[ST_GAIN_LSB +: 7] > ST_GAIN_MAX) ? ST_GAIN_MAX
                                                               : st_reg[ST_GAIN_LSB +: 7]; // R14
  assign step_slow = ck_reg[STEP_RATE_POS] & ~agc_on; // R21

  // Done flags follow applied==target, so a write drops them at once
  acr_gain_stepper #(.GAIN_W(7)) u_left_step (
    .core_clk_i   (core_clk_i),
    .sys_rst_i    (sys_rst_i),
    .clk_en_i     (clk_en_i),
    .step_i       (word_tick),
    .slow_i       (step_slow),
    .target_i     (dac_reg[LEFT_VOL_LSB +: 7]), // R24
    .reset_gain_i (DAC_GAIN_RST[LEFT_VOL_LSB +: 7]),
    .applied_o    (left_applied),
    .done_o       (left_done)
  );

  acr_gain_stepper #(.GAIN_W(7)) u_right_step (
    .core_clk_i   (core_clk_i),
    .sys_rst_i    (sys_rst_i),
    .clk_en_i     (clk_en_i),
    .step_i       (word_tick),
    .slow_i       (step_slow),
    .target_i     (dac_reg[RIGHT_VOL_LSB +: 7]), // R24
    .reset_gain_i (DAC_GAIN_RST[RIGHT_VOL_LSB +: 7]),
    .applied_o    (right_applied),
    .done_o       (right_done)
  );

  acr_gain_stepper #(.GAIN_W(7)) u_st_step (
    .core_clk_i   (core_clk_i),
    .sys_rst_i    (sys_rst_i),
    .clk_en_i     (clk_en_i),
    .step_i       (word_tick),
    .slow_i       (step_slow),
    .target_i     (st_target), // R24
    .reset_gain_i (SIDETONE_RST[ST_GAIN_LSB +: 7]),
    .applied_o    (st_applied),
    .done_o       (st_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Keyclick

  acr_click_gen u_click (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clk_en_i   (clk_en_i),
    .start_i    (ck_reg[CLICK_TRIG_POS]), // R17
    .tone_i     (ck_reg[CLICK_TONE_LSB +: 3]),
    .dur_i      (ck_reg[CLICK_DUR_LSB +: 4]),
    .tone_o     (click_tone_o),
    .busy_o     (click_busy),
    .done_o     (click_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        FMT_RATE_OFS: rdata_next = fmt_reg;
        HS_GAIN_OFS: begin
          rdata_next = hs_reg;
          if (agc_on) begin
            rdata_next[HS_MUTE_POS]         = autogain_mute_i; // R8
            rdata_next[HS_GAIN_LSB +: 7]    = autogain_gain_i; // R8
          end
        end
        DAC_GAIN_OFS: rdata_next = dac_reg;
        SIDETONE_OFS: begin
          rdata_next              = st_reg;
          rdata_next[ST_DONE_POS] = st_done; // R16
        end
        CLICK_OFS: begin
          rdata_next                 = ck_reg;
          rdata_next[LEFT_DONE_POS]  = left_done; // R22
          rdata_next[RIGHT_DONE_POS] = right_done; // R22
          if (agc_on) begin
            rdata_next[STEP_RATE_POS] = autogain_noise_i; // R21
          end
        end
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 16'h0000;
    end else if (clk_en_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs

  assign rec_highpass_select_o    = fmt_reg[15:14]; // R1
  assign sample_width_select_o    = fmt_reg[11:10]; // R2
  assign serial_framing_select_o  = acr_framing_t'(fmt_reg[9:8]); // R3
  assign playback_rate_divider_o  = fmt_reg[5:3]; // R5
  assign record_rate_divider_o    = fmt_reg[2:0]; // R6
  // Programmed or autogain-driven stage gain
  assign headset_input_mute_o     = agc_on ? autogain_mute_i : hs_reg[HS_MUTE_POS]; // R11
  assign headset_input_gain_o     = agc_on ? autogain_gain_i : hs_reg[HS_GAIN_LSB +: 7]; // R11
  assign autogain_target_level_o  = hs_reg[7:5]; // R9
  assign autogain_time_constant_o = hs_reg[4:1]; // R10
  assign autogain_enable_o        = hs_reg[AGC_EN_POS]; // R11
  assign left_playback_mute_o     = dac_reg[LEFT_MUTE_POS]; // R12
  assign left_playback_volume_o   = left_applied; // R13
  assign right_playback_mute_o    = dac_reg[RIGHT_MUTE_POS]; // R12
  assign right_playback_volume_o  = right_applied; // R13
  assign sidetone_mute_o          = st_reg[ST_MUTE_POS]; // R14
  assign sidetone_gain_o          = st_applied; // R14
  assign cellphone_to_record_route_o = st_reg[3]; // R15
  assign click_amplitude_o        = ck_reg[CLICK_AMP_LSB +: 3]; // R18
  assign click_active_o           = click_busy;

endmodule : acr_regs

// ==== tb/acr_regs_sva.sv ====
// Checker: port-level properties of the codec control register bank
`timescale 1ns/10ps
module acr_regs_chk
  import acr_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  input wire logic              clk_en_i,
  input wire logic              reg_wr_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              headset_selected_i,
  input wire logic [6:0]        autogain_gain_i,
  input wire logic              autogain_mute_i,
  input wire logic              autogain_enable_o,
  input wire logic              headset_input_mute_o,
  input wire logic [6:0]        headset_input_gain_o,
  input wire logic [1:0]        rec_highpass_select_o,
  input wire logic [1:0]        sample_width_select_o,
  input wire logic              left_playback_mute_o,
  input wire logic              right_playback_mute_o,
  input wire logic [6:0]        left_playback_volume_o,
  input wire logic [6:0]        sidetone_gain_o,
  input wire logic              cellphone_to_record_route_o,
  input wire logic              click_active_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire logic wr_go;
  assign wr_go = reg_wr_i & clk_en_i;
  ////////////////////////////////////////////////////////////////////////////
  property p_hpf; wr_go && reg_addr_i == FMT_RATE_OFS |=> rec_highpass_select_o == $past(reg_wdata_i[15:14]);
  endproperty
  a_hpf: assert property (p_hpf) else $error("highpass field not written");
  property p_width; wr_go && reg_addr_i == FMT_RATE_OFS |=> sample_width_select_o == $past(reg_wdata_i[11:10]);
  endproperty
  a_width: assert property (p_width) else $error("width field not written");
  property p_hs_manual; wr_go && reg_addr_i == HS_GAIN_OFS && !reg_wdata_i[0]
    |=> headset_input_gain_o == $past(reg_wdata_i[14:8]) && headset_input_mute_o == $past(reg_wdata_i[15]);
  endproperty
  a_hs_manual: assert property (p_hs_manual) else $error("headset gain not programmed value");
  property p_agc_mux; autogain_enable_o && headset_selected_i
    |-> headset_input_gain_o == autogain_gain_i && headset_input_mute_o == autogain_mute_i;
  endproperty
  a_agc_mux: assert property (p_agc_mux) else $error("headset gain not from gain controller");
  property p_mute; wr_go && reg_addr_i == DAC_GAIN_OFS
    |=> left_playback_mute_o == $past(reg_wdata_i[15]) && right_playback_mute_o == $past(reg_wdata_i[7]);
  endproperty
  a_mute: assert property (p_mute) else $error("playback mute not written");
  property p_vol_step; $changed(left_playback_volume_o)
    |-> (left_playback_volume_o - $past(left_playback_volume_o)) inside {7'h01, 7'h7F};
  endproperty
  a_vol_step: assert property (p_vol_step) else $error("volume jumped more than one step");
  property p_st_cap; sidetone_gain_o <= ST_GAIN_MAX;
  endproperty
  a_st_cap: assert property (p_st_cap) else $error("sidetone gain above cap");
  property p_route; wr_go && reg_addr_i == SIDETONE_OFS |=> cellphone_to_record_route_o == $past(reg_wdata_i[3]);
  endproperty
  a_route: assert property (p_route) else $error("route bit not written");
  property p_click; wr_go && reg_addr_i == CLICK_OFS && reg_wdata_i[15] && !click_active_o
    |=> ##[0:3] click_active_o;
  endproperty
  a_click: assert property (p_click) else $error("click burst did not start");
endmodule : acr_regs_chk

bind acr_regs acr_regs_chk u_chk (.core_clk_i, .sys_rst_i, .clk_en_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
  .headset_selected_i, .autogain_gain_i, .autogain_mute_i, .autogain_enable_o, .headset_input_mute_o,
  .headset_input_gain_o, .rec_highpass_select_o, .sample_width_select_o, .left_playback_mute_o,
  .right_playback_mute_o, .left_playback_volume_o, .sidetone_gain_o, .cellphone_to_record_route_o, .click_active_o);

// ==== tb/acr_regs_test.sv ====
// Testbench: self-checking scenarios for the codec control register bank
`timescale 1ns/10ps
module acr_regs_test import acr_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, rate_pin = 1'b0, hs_sel = 1'b0;
  logic ag_mute = 1'b1, ag_noise = 1'b1, run = 1'b0, strobe;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [6:0] ag_gain = 7'h33, hs_gain, lvol, rvol, st_gain;
  logic [1:0] hpf, sample_width_select;
  acr_framing_t frm;
  logic [2:0] pdiv, rdiv, ag_tgt, amp;
  logic [3:0] ag_tc;
  logic rate_o, hs_mute, ag_en, lmute, rmute, st_mute, route, tone, active;
  int err_count = 0;
  int checks = 0;
  always #20 clk = ~clk;
  acr_strobe_model u_host (.run_i(run), .strobe_o(strobe));
  acr_regs u_dut (.core_clk_i(clk), .sys_rst_i(rst), .clk_en_i(1'b1), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .record_word_strobe_i(strobe),
    .reference_rate_select_i(rate_pin), .headset_selected_i(hs_sel), .autogain_gain_i(ag_gain),
    .autogain_mute_i(ag_mute), .autogain_noise_i(ag_noise), .rec_highpass_select_o(hpf),
    .sample_width_select_o(sample_width_select), .serial_framing_select_o(frm), .playback_rate_divider_o(pdiv),
    .record_rate_divider_o(rdiv), .reference_rate_select_o(rate_o), .headset_input_mute_o(hs_mute),
    .headset_input_gain_o(hs_gain), .autogain_target_level_o(ag_tgt), .autogain_time_constant_o(ag_tc),
    .autogain_enable_o(ag_en), .left_playback_mute_o(lmute), .left_playback_volume_o(lvol),
    .right_playback_mute_o(rmute), .right_playback_volume_o(rvol), .sidetone_mute_o(st_mute),
    .sidetone_gain_o(st_gain), .cellphone_to_record_route_o(route), .click_amplitude_o(amp),
    .click_tone_o(tone), .click_active_o(active));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_s  <= 1'b1;
    addr  <= a;
    wdata <= d;
    tick();
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string what);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    tick();
    rd_s <= 1'b0;
    chk(what, exp, rdata);
  endtask : rd
  // Cycles between two successive steps of the right volume
  task automatic step_gap(output int n);
    logic [6:0] v;
    int k;
    v = rvol;
    for (k = 0; k < 200 && rvol === v; k++) tick();
    v = rvol;
    for (n = 0; n < 200 && rvol === v; n++) tick();
  endtask : step_gap
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(FMT_RATE_OFS, FMT_RATE_RST, "fmt rst");
    rd(HS_GAIN_OFS, HS_GAIN_RST, "hs rst");
    rd(DAC_GAIN_OFS, DAC_GAIN_RST, "dac rst");
    rd(SIDETONE_OFS, SIDETONE_RST | 16'h0001, "st rst");
    rd(CLICK_OFS, CLICK_RST | 16'h000C, "click rst");
    rd(3'h5, 16'h0000, "unmapped");
    chk("amp rst", 16'h0004, 16'(amp));
    rate_pin <= 1'b1;
    repeat (4) tick();
    chk("rate sel", 16'h0001, 16'(rate_o));
  endtask : t_reset
  task automatic t_format;
    logic [1:0] c;
    logic [15:0] d;
    wr(FMT_RATE_OFS, 16'hFFFF);
    rd(FMT_RATE_OFS, FMT_RATE_WMASK, "fmt ro");
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      d = {c, 2'b11, c, c, 2'b11, 1'b0, c, ~c[1], c};
      wr(FMT_RATE_OFS, d);
      chk("hpf", 16'(c), 16'(hpf));
      chk("sample_width_select", 16'(c), 16'(sample_width_select));
      chk("frame", 16'(c), 16'(frm));
      chk("pdiv", 16'({1'b0, c}), 16'(pdiv));
      chk("rdiv", 16'({~c[1], c}), 16'(rdiv));
      rd(FMT_RATE_OFS, d & FMT_RATE_WMASK, "fmt rd");
    end
  endtask : t_format
  task automatic t_dac;
    int n;
    wr(DAC_GAIN_OFS, 16'h7E7D);
    chk("mutes", 16'h0000, 16'({lmute, rmute}));
    rd(CLICK_OFS, CLICK_RST, "flags busy");
    run <= 1'b1;
    step_gap(n);
    chk("fast gap", 16'h0008, 16'(n));
    chk("lvol", 16'h007E, 16'(lvol));
    chk("rvol", 16'h007D, 16'(rvol));
    rd(CLICK_OFS, CLICK_RST | 16'h000C, "flags done");
    wr(CLICK_OFS, CLICK_RST | 16'h0800);
    wr(DAC_GAIN_OFS, 16'h7E7B);
    step_gap(n);
    chk("slow gap", 16'h0010, 16'(n));
  endtask : t_dac
  task automatic t_sidetone;
    wr(SIDETONE_OFS, 16'h7F08);
    rd(SIDETONE_OFS, 16'h7F08, "st busy");
    for (int k = 0; k < 2000 && st_gain !== ST_GAIN_MAX; k++) tick();
    repeat (40) tick();
    chk("st cap", 16'(ST_GAIN_MAX), 16'(st_gain));
    chk("st route", 16'h0001, 16'({st_mute, route}));
    rd(SIDETONE_OFS, 16'h7F09, "st done");
  endtask : t_sidetone
  task automatic t_agc;
    @(posedge clk);
    hs_sel <= 1'b1;
    wr(HS_GAIN_OFS, 16'h2A6B);
    chk("agc en", 16'h0001, 16'(ag_en));
    chk("agc tgt", 16'h0003, 16'(ag_tgt));
    chk("agc tc", 16'h0005, 16'(ag_tc));
    chk("agc gain", 16'h00B3, 16'({hs_mute, hs_gain}));
    rd(HS_GAIN_OFS, 16'hB36B, "agc rd");
    rd(CLICK_OFS, 16'h4C1C, "noise hi");
    ag_noise <= 1'b0;
    rd(CLICK_OFS, 16'h441C, "noise lo");
    wr(CLICK_OFS, CLICK_RST);
    hs_sel <= 1'b0;
    rd(HS_GAIN_OFS, 16'h2A6B, "unsel rd");
    chk("unsel gain", 16'h002A, 16'(hs_gain));
    wr(HS_GAIN_OFS, 16'h2A6A);
    rd(CLICK_OFS, 16'h4C1C, "step kept");
  endtask : t_agc
  task automatic t_click;
    int k;
    int rises;
    logic last;
    rises = 0;
    wr(CLICK_OFS, 16'hF700);
    chk("amp", 16'h0007, 16'(amp));
    rd(CLICK_OFS, 16'hF70C, "trig busy");
    // Tone idles low before the burst, so the opening rise counts
    last = 1'b0;
    for (k = 0; k < 20000 && active === 1'b1; k++) begin
      tick();
      if (tone === 1'b1 && last === 1'b0) rises++;
      last = tone;
    end
    chk("burst len", 16'h0001, 16'(k inside {[6200:6260]}));
    chk("tone rises", 16'h0002, 16'(rises));
    repeat (2) tick();
    rd(CLICK_OFS, 16'h770C, "trig clr");
  endtask : t_click
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (err_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    #800000;
    err_count++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_format();
    t_dac();
    t_sidetone();
    t_agc();
    t_click();
    test_done();
  end
endmodule : acr_regs_test

// ==== tb/acr_strobe_model.sv ====
// Partner model: word strobe source pacing the soft-steppers
`timescale 1ns/10ps
module acr_strobe_model #(
  parameter int PHASE_NS = 13,
  parameter int HALF_NS  = 160
) (
  input  wire logic run_i,
  output logic      strobe_o
);
  // Strobe stands low outside frames
  initial begin
    strobe_o = 1'b0;
    #(PHASE_NS);
    forever begin
      #(HALF_NS);
      strobe_o = run_i ? ~strobe_o : 1'b0;
    end
  end
endmodule : acr_strobe_model
